/* File: design/rxdma_consts.vh */
`ifndef RXDMA_CONSTS_VH
`define RXDMA_CONSTS_VH

`define RXD_FIFO_AW 6
`define RXD_PAGE_LOG2 12
`define RXD_BLK_LOG2 8
`define RXD_FLUSH_BASE 8'h10

`define RXD_A_RDP 8'h00
`define RXD_A_SGP 8'h04
`define RXD_A_RWC 8'h08
`define RXD_A_TDP 8'h0C
`define RXD_A_TWC 8'h10
`define RXD_A_DPM 8'h14
`define RXD_A_OCR 8'h18
`define RXD_A_MISC 8'h1C
`define RXD_A_IMR 8'h20
`define RXD_A_ISR 8'h24
`define RXD_A_PIO 8'h28

`define RXD_OCR_RX_QUEUE_ENABLE 0
`define RXD_OCR_RX_DMA_ENABLE 1
`define RXD_OCR_GPO_LO 2
`define RXD_OCR_SIZE_LO 4
`define RXD_OCR_PACK_LO 6
`define RXD_OCR_ICM 8
`define RXD_OCR_SG 9
`define RXD_OCR_CNTEN 10
`define RXD_OCR_BURST_LO 16
`define RXD_OCR_INIT_LO 24
`define RXD_OCR_RST 32'h00000000

`define RXD_MISC_THR_LO 0
`define RXD_MISC_RB_LO 3
`define RXD_MISC_FL_LO 5
`define RXD_MISC_RST 7'h00

`define RXD_IRQ_DONE 0
`define RXD_IRQ_GPI1 1
`define RXD_IRQ_GPI2 2
`define RXD_IRQ_RFE 3
`define RXD_IMR_RST 4'h0

`define RXD_TAG_DATA 2'h0
`define RXD_TAG_RXA 2'h1
`define RXD_TAG_TXA 2'h2
`define RXD_TAG_CNT 2'h3

`define RXD_SIZE_BYTE 2'h0
`define RXD_SIZE_HALF 2'h1
`define RXD_SIZE_WORD 2'h2

`endif

/* File: design/rxdma_fifo_mem.v */
`timescale 1ns/100ps
module rxdma_fifo_mem #(
    parameter AW = 6,
    parameter DW = 34
)(
    input wire hclk,
    input wire we,
    input wire [AW-1:0] waddr,
    input wire [DW-1:0] wdata,
    input wire [AW-1:0] raddr,
    output reg [DW-1:0] rdata
);
reg [DW-1:0] mem [0:(1<<AW)-1];

// Bypass so an entry written into an empty queue is the head next cycle
always @(posedge hclk)
begin
    if (we)
        mem[waddr] <= wdata;
    if (we && (waddr == raddr))
        rdata <= wdata;
    else
        rdata <= mem[raddr];
end
endmodule // rxdma_fifo_mem

/* File: design/rxdma_packer.v */
`timescale 1ns/100ps
`include "rxdma_consts.vh"
module rxdma_packer (
    input wire hclk,
    input wire hresetn,
    input wire clear,
    input wire push,
    input wire [1:0] size,
    input wire [1:0] start_off,
    input wire [31:0] din,
    output reg word_valid,
    output reg [31:0] word_out,
    output wire [1:0] leftover,
    output wire [31:0] partial
);
reg [31:0] acc_q;
reg [1:0] idx_q;
reg [1:0] cnt_q;
reg fresh_q;
reg [31:0] acc_d;
reg [1:0] idx_d;
reg [1:0] cnt_d;
reg [2:0] nb;
integer k;

assign leftover = cnt_q;
assign partial = acc_q;

////////////////////////////////////////////////////////////////////////////
always @*
begin
    acc_d = acc_q;
    idx_d = fresh_q ? start_off : idx_q;
    cnt_d = cnt_q;
    word_valid = 1'b0;
    word_out = 32'h00000000;
    if (size == `RXD_SIZE_WORD)
        nb = 3'h4;
    else if (size == `RXD_SIZE_HALF)
        nb = 3'h2;
    else
        nb = 3'h1;
    if (push)
    begin
        for (k = 0; k < 4; k = k + 1)
        begin
            if (k < nb)
            begin
                acc_d[{idx_d, 3'b000} +: 8] = din[k*8 +: 8];
                if (idx_d == 2'h3)
                begin
                    word_valid = 1'b1;
                    word_out = acc_d;
                    acc_d = 32'h00000000;
                    idx_d = 2'h0;
                    cnt_d = 2'h0;
                end
                else
                begin
                    idx_d = idx_d + 2'h1;
                    cnt_d = cnt_d + 2'h1;
                end
            end
        end
    end
end

// Lane follows the offset until the first byte, so an offset written
// together with the queue enable still applies
always @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
    begin
        acc_q <= 32'h00000000;
        idx_q <= 2'h0;
        cnt_q <= 2'h0;
        fresh_q <= 1'b1;
    end
    else if (clear)
    begin
        acc_q <= 32'h00000000;
        idx_q <= start_off;
        cnt_q <= 2'h0;
        fresh_q <= 1'b1;
    end
    else
    begin
        acc_q <= acc_d;
        idx_q <= idx_d;
        cnt_q <= cnt_d;
        fresh_q <= fresh_q && !push;
    end
end
endmodule // rxdma_packer

/* File: design/rxdma_top.v */
// The register addresses and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/100ps
`include "rxdma_consts.vh"
// Contract
// - Data strobe captures bus word into FIFO.
// - Room indication drops past programmed threshold.
// - Write bursts start at receive-burst count words.
// - Burst stops when FIFO drains.
// - Bursts split at every 64-word boundary.
// - Flush counter forces residual words out.
// - Page boundary fetches next scatter/gather address.
// - Word count ends DMA; remainder via flush.
// - Count-zero completion raises masked system interrupt.
// - Control bit drives option general output pin.
// - Packer starts at programmed byte offset.
// - Leftover bytes stay, count reported, PIO read.
// - FIFO-empty flag ignores packer bytes.
// - Option input two can raise interrupt.
// - Both address strobes load burst and count.
// - Transmit address entry loads pointer, starts transmit.
// - Controller mode sets first burst to size.
// - Receive address entry loads pointer, no increment.
// - Mask merges option address with pointer bits.
// - Address entries bypass packer, one cycle.
module rxdma_top #(
    parameter AW = `RXD_FIFO_AW,
    parameter PAGE_LOG2 = `RXD_PAGE_LOG2
)(
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire [31:0] option_addr_data_bus,
    input wire rx_data_strobe_n,
    input wire rx_addr_strobe_n,
    input wire tx_addr_strobe_n,
    input wire [2:0] option_gp_in_pin_n,
    output reg rx_room_avail_n,
    output reg [1:0] option_gp_out_pin,
    output reg sys_irq_n,
    output reg dma_burst,
    output reg dma_wr_req,
    output reg dma_rd_req,
    output reg [31:0] dma_addr,
    output reg [31:0] dma_wr_data,
    input wire dma_wr_ack,
    input wire dma_rd_ack,
    input wire [31:0] dma_rd_data,
    output reg [31:0] tx_mem_pointer,
    output reg [23:0] tx_word_count,
    output reg [7:0] tx_burst_len,
    output reg [7:0] tx_first_burst_len,
    output reg tx_dma_start
);
localparam [AW:0] DEPTH = {1'b1, {AW{1'b0}}};
localparam [1:0] ST_IDLE = 2'h0;
localparam [1:0] ST_WR = 2'h1;
localparam [1:0] ST_NEXT = 2'h2;
localparam [1:0] ST_SGF = 2'h3;

function [3:0] bcount;
    input [1:0] c;
    bcount = 4'h1 << c;
endfunction

function [31:0] merge;
    input [31:0] base;
    input [31:0] opt;
    input [31:0] mask;
    merge = (base & ~mask) | (opt & mask);
endfunction

reg [31:0] rx_mem_pointer_q, rx_page_table_pointer_q, addr_merge_mask_q;
reg [23:0] rx_word_count_q;
reg [31:0] option_control_reg_q;
reg [6:0] misc_q;
reg [3:0] irq_mask_reg_q;
reg done_q;
reg [1:0] state_q;
reg [7:0] flush_q;
reg [AW:0] count_q;
reg [AW-1:0] wp_q, rp_q;
reg [31:0] ad_s1_q, ad_s2_q;
reg [2:0] stb_s1_q, stb_s2_q, stb_s3_q;
reg [2:0] gpi_s1_q, gpi_s2_q;
reg rd_pend_q, wr_pend_q;
reg [7:0] ra_q, wa_q;
reg push;
reg [33:0] wentry;
reg pop;
reg [31:0] rdv;

wire rx_queue_enable = option_control_reg_q[`RXD_OCR_RX_QUEUE_ENABLE];
wire rx_dma_enable = option_control_reg_q[`RXD_OCR_RX_DMA_ENABLE];
wire cnten = option_control_reg_q[`RXD_OCR_CNTEN];
wire sgen = option_control_reg_q[`RXD_OCR_SG];
wire [2:0] thr = misc_q[`RXD_MISC_THR_LO +: 3];
wire [3:0] bn = bcount(misc_q[`RXD_MISC_RB_LO +: 2]);
wire [7:0] flen = `RXD_FLUSH_BASE << misc_q[`RXD_MISC_FL_LO +: 2];
wire [2:0] ev = stb_s2_q & ~stb_s3_q;
wire [33:0] head;
wire [1:0] hd_tag = head[33:32];
wire [31:0] hd = head[31:0];
wire head_ok = (count_q != {(AW+1){1'b0}});
wire [AW:0] free = DEPTH - count_q;
wire [AW-1:0] rp_d = rp_q + {{(AW-1){1'b0}}, pop};
wire pk_valid;
wire [31:0] pk_word;
wire [1:0] pk_left;
wire [31:0] pk_part;
wire pio_rd = rd_pend_q && (ra_q == `RXD_A_PIO);
wire cnt_ok = !cnten || (rx_word_count_q != 24'h000000);
wire cnt_low = cnten && (rx_word_count_q < {20'h00000, bn});
wire flush_due = (flush_q == 8'h00) && head_ok;
wire enough = ({3'h0, count_q} >= {{AW{1'b0}}, bn}) && !cnt_low;
wire start_ok = rx_dma_enable && cnt_ok
    && (enough || flush_due);
wire [31:0] rdp_inc = rx_mem_pointer_q + 32'h00000004;
// Word about to go out would open a new 64-word block
wire blk_end = (rx_mem_pointer_q[`RXD_BLK_LOG2-1:2]
    == {(`RXD_BLK_LOG2-2){1'b0}});
wire pg_end = (rdp_inc[PAGE_LOG2-1:0] == {PAGE_LOG2{1'b0}});
wire [3:0] isr = {head_ok ? 1'b0 : 1'b1, gpi_s2_q[2], gpi_s2_q[1], done_q};
wire st_wr = hsel && htrans[1] && hready;

////////////////////////////////////////////////////////////////////////////
// Two flops on every option pin, three on the strobes; the data bus rides with its strobe
always @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
    begin
        ad_s1_q <= 32'h00000000;
        ad_s2_q <= 32'h00000000;
        stb_s1_q <= 3'h0;
        stb_s2_q <= 3'h0;
        stb_s3_q <= 3'h0;
        gpi_s1_q <= 3'h0;
        gpi_s2_q <= 3'h0;
    end
    else
    begin
        ad_s1_q <= option_addr_data_bus;
        ad_s2_q <= ad_s1_q;
        stb_s1_q <= ~{tx_addr_strobe_n, rx_addr_strobe_n, rx_data_strobe_n};
        stb_s2_q <= stb_s1_q;
        stb_s3_q <= stb_s2_q;
        gpi_s1_q <= ~option_gp_in_pin_n;
        gpi_s2_q <= gpi_s1_q;
    end
end

rxdma_packer u_pack (
    .hclk(hclk),
    .hresetn(hresetn),
    .clear(!rx_queue_enable || pio_rd),
    .push(ev[0] && rx_queue_enable),
    .size(option_control_reg_q[`RXD_OCR_SIZE_LO +: 2]),
    .start_off(option_control_reg_q[`RXD_OCR_PACK_LO +: 2]),
    .din(ad_s2_q),
    .word_valid(pk_valid),
    .word_out(pk_word),
    .leftover(pk_left),
    .partial(pk_part)
);

// Address entries skip the packer and are taken as one whole word
always @*
begin
    push = 1'b0;
    wentry = {`RXD_TAG_DATA, pk_word};
    if (ev[2] && ev[1])
    begin
        push = 1'b1;
        wentry = {`RXD_TAG_CNT, ad_s2_q};
    end
    else if (ev[1])
    begin
        push = 1'b1;
        wentry = {`RXD_TAG_RXA, ad_s2_q};
    end
    else if (ev[2])
    begin
        push = 1'b1;
        wentry = {`RXD_TAG_TXA, ad_s2_q};
    end
    else if (pk_valid)
        push = 1'b1;
    if (!rx_queue_enable || (count_q == DEPTH))
        push = 1'b0;
end

rxdma_fifo_mem #(
    .AW(AW),
    .DW(34)
) u_mem (
    .hclk(hclk),
    .we(push),
    .waddr(wp_q),
    .wdata(wentry),
    .raddr(rp_d),
    .rdata(head)
);

always @*
begin
    pop = 1'b0;
    if (state_q == ST_IDLE && head_ok && rx_queue_enable)
        pop = (hd_tag != `RXD_TAG_DATA);
    else if (state_q == ST_WR)
        pop = dma_wr_ack;
end

////////////////////////////////////////////////////////////////////////////
// Queue pointers, flush counter and pin outputs
always @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
    begin
        wp_q <= {AW{1'b0}};
        rp_q <= {AW{1'b0}};
        count_q <= {(AW+1){1'b0}};
        flush_q <= `RXD_FLUSH_BASE;
        rx_room_avail_n <= 1'b1;
        option_gp_out_pin <= 2'h0;
        sys_irq_n <= 1'b1;
    end
    else if (!rx_queue_enable)
    begin
        wp_q <= {AW{1'b0}};
        rp_q <= {AW{1'b0}};
        count_q <= {(AW+1){1'b0}};
        flush_q <= flen;
        rx_room_avail_n <= 1'b1;
        option_gp_out_pin <= option_control_reg_q[`RXD_OCR_GPO_LO +: 2];
        sys_irq_n <= ~|(isr & irq_mask_reg_q);
    end
    else
    begin
        wp_q <= wp_q + {{(AW-1){1'b0}}, push};
        rp_q <= rp_d;
        count_q <= count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        // Reload on any arrival so only an idle trickle gets flushed
        if (push || !head_ok || state_q != ST_IDLE)
            flush_q <= flen;
        else if (flush_q != 8'h00)
            flush_q <= flush_q - 8'h01;
        // Margin of thr words covers strobes still in the synchroniser
        rx_room_avail_n <= (free <= {{(AW-2){1'b0}}, thr});
        option_gp_out_pin <=
            option_control_reg_q[`RXD_OCR_GPO_LO +: 2];
        sys_irq_n <= ~|(isr & irq_mask_reg_q);
    end
end

////////////////////////////////////////////////////////////////////////////
// Bus slave: writes land at the end of the data phase, reads take one wait
always @*
begin
    rdv = 32'h00000000;
    case (ra_q)
        `RXD_A_RDP: rdv = rx_mem_pointer_q;
        `RXD_A_SGP: rdv = rx_page_table_pointer_q;
        `RXD_A_RWC: rdv = {8'h00, rx_word_count_q};
        `RXD_A_TDP: rdv = tx_mem_pointer;
        `RXD_A_TWC: rdv = {8'h00, tx_word_count};
        `RXD_A_DPM: rdv = addr_merge_mask_q;
        `RXD_A_OCR: rdv = option_control_reg_q;
        `RXD_A_MISC: rdv = {25'h0000000, misc_q};
        `RXD_A_IMR: rdv = {28'h0000000, irq_mask_reg_q};
        `RXD_A_ISR: rdv = {26'h0000000, pk_left, isr};
        `RXD_A_PIO: rdv = pk_part;
        default: rdv = 32'h00000000;
    endcase
end

always @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
    begin
        hrdata <= 32'h00000000;
        hreadyout <= 1'b1;
        hresp <= 1'b0;
        rd_pend_q <= 1'b0;
        wr_pend_q <= 1'b0;
        ra_q <= 8'h00;
        wa_q <= 8'h00;
    end
    else
    begin
        hresp <= 1'b0;
        wr_pend_q <= st_wr && hwrite;
        wa_q <= haddr[7:0];
        if (rd_pend_q)
        begin
            hrdata <= rdv;
            hreadyout <= 1'b1;
            rd_pend_q <= 1'b0;
        end
        else if (st_wr && !hwrite)
        begin
            ra_q <= haddr[7:0];
            hreadyout <= 1'b0;
            rd_pend_q <= 1'b1;
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// Head dispatch, write bursts, page table fetch and register file
always @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
    begin
        state_q <= ST_IDLE;
        dma_burst <= 1'b0;
        dma_wr_req <= 1'b0;
        dma_rd_req <= 1'b0;
        dma_addr <= 32'h00000000;
        dma_wr_data <= 32'h00000000;
        rx_mem_pointer_q <= 32'h00000000;
        rx_page_table_pointer_q <= 32'h00000000;
        rx_word_count_q <= 24'h000000;
        addr_merge_mask_q <= 32'h00000000;
        option_control_reg_q <= `RXD_OCR_RST;
        misc_q <= `RXD_MISC_RST;
        irq_mask_reg_q <= `RXD_IMR_RST;
        done_q <= 1'b0;
        tx_mem_pointer <= 32'h00000000;
        tx_word_count <= 24'h000000;
        tx_burst_len <= 8'h00;
        tx_first_burst_len <= 8'h00;
        tx_dma_start <= 1'b0;
    end
    else
    begin
        tx_dma_start <= 1'b0;
        case (state_q)
            ST_IDLE:
            begin
                if (head_ok && rx_queue_enable)
                begin
                    case (hd_tag)
                        `RXD_TAG_RXA:
                            rx_mem_pointer_q <= merge(rx_mem_pointer_q, hd,
                                addr_merge_mask_q);
                        `RXD_TAG_TXA:
                        begin
                            tx_mem_pointer <= merge(tx_mem_pointer, hd,
                                addr_merge_mask_q);
                            tx_dma_start <= 1'b1;
                        end
                        `RXD_TAG_CNT:
                        begin
                            tx_burst_len <= hd[31:24];
                            tx_word_count <= hd[23:0];
                            if (option_control_reg_q[`RXD_OCR_ICM])
                                tx_first_burst_len <= hd[31:24];
                        end
                        default:
                        begin
                            if (start_ok)
                            begin
                                state_q <= ST_WR;
                                dma_burst <= 1'b1;
                                dma_wr_req <= 1'b1;
                                dma_addr <= rx_mem_pointer_q;
                                dma_wr_data <= hd;
                            end
                        end
                    endcase
                end
            end
            ST_WR:
            begin
                if (dma_wr_ack)
                begin
                    dma_wr_req <= 1'b0;
                    rx_mem_pointer_q <= rdp_inc;
                    if (cnten && rx_word_count_q != 24'h000000)
                    begin
                        rx_word_count_q <= rx_word_count_q - 24'h000001;
                        if (rx_word_count_q == 24'h000001)
                            done_q <= 1'b1;
                    end
                    if (sgen && pg_end)
                    begin
                        state_q <= ST_SGF;
                        dma_burst <= 1'b0;
                        dma_rd_req <= 1'b1;
                        dma_addr <= rx_page_table_pointer_q;
                    end
                    else
                        state_q <= ST_NEXT;
                end
            end
            ST_NEXT:
            begin
                // Head was refreshed by the pop one cycle ago
                if (head_ok && hd_tag == `RXD_TAG_DATA && rx_dma_enable && cnt_ok
                    && !blk_end && rx_queue_enable)
                begin
                    state_q <= ST_WR;
                    dma_wr_req <= 1'b1;
                    dma_addr <= rx_mem_pointer_q;
                    dma_wr_data <= hd;
                end
                else
                begin
                    state_q <= ST_IDLE;
                    dma_burst <= 1'b0;
                end
            end
            default:
            begin
                if (dma_rd_ack)
                begin
                    dma_rd_req <= 1'b0;
                    rx_mem_pointer_q <= dma_rd_data;
                    rx_page_table_pointer_q <= rx_page_table_pointer_q
                        + 32'h00000004;
                    state_q <= ST_IDLE;
                end
            end
        endcase
        if (wr_pend_q)
        begin
            case (wa_q)
                `RXD_A_RDP: rx_mem_pointer_q <= hwdata;
                `RXD_A_SGP: rx_page_table_pointer_q <= hwdata;
                `RXD_A_RWC: rx_word_count_q <= hwdata[23:0];
                `RXD_A_TDP: tx_mem_pointer <= hwdata;
                `RXD_A_TWC: tx_word_count <= hwdata[23:0];
                `RXD_A_DPM: addr_merge_mask_q <= hwdata;
                `RXD_A_OCR:
                begin
                    option_control_reg_q <= hwdata;
                    tx_burst_len <= hwdata[`RXD_OCR_BURST_LO +: 8];
                    tx_first_burst_len <= hwdata[`RXD_OCR_INIT_LO +: 8];
                end
                `RXD_A_MISC: misc_q <= hwdata[6:0];
                `RXD_A_IMR: irq_mask_reg_q <= hwdata[3:0];
                // A completion in the same cycle keeps the flag set
                `RXD_A_ISR: done_q <= done_q && !hwdata[`RXD_IRQ_DONE]
                    || (state_q == ST_WR && dma_wr_ack && cnten
                    && rx_word_count_q == 24'h000001);
                default: done_q <= done_q;
            endcase
        end
    end
end
endmodule // rxdma_top

/* File: testbench/rxdma_assertions.sv */
`timescale 1ns/100ps
module rxdma_checker (
    input wire hclk,
    input wire hresetn,
    input wire hreadyout,
    input wire dma_burst,
    input wire dma_wr_req,
    input wire dma_rd_req,
    input wire dma_wr_ack,
    input wire dma_rd_ack,
    input wire [31:0] dma_addr,
    input wire [31:0] dma_wr_data,
    input wire tx_dma_start
);
default clocking cb @(posedge hclk); endclocking
default disable iff (!hresetn);
sequence s_word_done;
    dma_wr_ack ##1 (dma_burst && !dma_wr_req) ##1 dma_wr_req;
endsequence
a_req_in_burst: assert property (dma_wr_req |-> dma_burst)
    else $error("write request outside a burst");
a_wr_held: assert property (dma_wr_req && !dma_wr_ack |=>
    dma_wr_req && $stable(dma_addr) && $stable(dma_wr_data))
    else $error("write word dropped before ack");
a_rd_held: assert property (dma_rd_req && !dma_rd_ack |=>
    dma_rd_req && $stable(dma_addr))
    else $error("table read dropped before ack");
a_addr_step: assert property (s_word_done |->
    dma_addr == $past(dma_addr, 2) + 32'h4)
    else $error("pointer did not step by one word");
a_no_cross: assert property ($rose(dma_wr_req) && $past(dma_burst)
    |-> dma_addr[7:0] != 8'h00)
    else $error("burst crossed a 64-word boundary");
a_burst_end: assert property ($fell(dma_burst) |-> !dma_wr_req)
    else $error("burst ended with a word pending");
a_ready_pulse: assert property (!hreadyout |=> hreadyout)
    else $error("wait state longer than one cycle");
a_start_pulse: assert property (tx_dma_start |=> !tx_dma_start)
    else $error("transmit start longer than one cycle");
a_req_excl: assert property (!(dma_wr_req && dma_rd_req))
    else $error("read and write requested together");
endmodule // rxdma_checker
bind rxdma_top rxdma_checker u_rxdma_checker (.hclk(hclk),
    .hresetn(hresetn), .hreadyout(hreadyout), .dma_burst(dma_burst),
    .dma_wr_req(dma_wr_req), .dma_rd_req(dma_rd_req),
    .dma_wr_ack(dma_wr_ack), .dma_rd_ack(dma_rd_ack),
    .dma_addr(dma_addr), .dma_wr_data(dma_wr_data),
    .tx_dma_start(tx_dma_start));

/* File: testbench/rxdma_mem_model.sv */
`timescale 1ns/100ps
module rxdma_mem_model #(
    parameter [31:0] NEXT_PAGE = 32'h00004000
)(
    input wire hclk,
    input wire hresetn,
    input wire dma_wr_req,
    input wire dma_rd_req,
    input wire [3:0] slow,
    output logic dma_wr_ack,
    output logic dma_rd_ack,
    output logic [31:0] dma_rd_data
);
logic [3:0] wait_q;
always @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
    begin
        wait_q <= 4'h0;
        dma_wr_ack <= 1'b0;
        dma_rd_ack <= 1'b0;
        dma_rd_data <= 32'h0;
    end
    else
    begin
        dma_wr_ack <= 1'b0;
        dma_rd_ack <= 1'b0;
        // Read data is only valid with the ack, so it churns otherwise
        dma_rd_data <= ~dma_rd_data;
        if ((dma_wr_req || dma_rd_req) && !dma_wr_ack && !dma_rd_ack)
        begin
            if (wait_q == slow)
            begin
                wait_q <= 4'h0;
                dma_wr_ack <= dma_wr_req;
                dma_rd_ack <= dma_rd_req;
                if (dma_rd_req)
                    dma_rd_data <= NEXT_PAGE;
            end
            else
                wait_q <= wait_q + 4'h1;
        end
    end
end
endmodule // rxdma_mem_model

/* File: testbench/tb_top.sv */
`timescale 1ns/100ps
`include "rxdma_consts.vh"
module tb_top;
typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} rxd_row_t;
logic hclk = 1'b0;
logic hresetn = 1'b0;
logic hsel = 1'b0;
logic [31:0] haddr = 32'h0;
logic [1:0] htrans = 2'h0;
logic hwrite = 1'b0;
logic [31:0] hwdata = 32'h0;
logic [31:0] option_addr_data_bus = 32'h0;
logic rx_data_strobe_n = 1'b1;
logic rx_addr_strobe_n = 1'b1;
logic tx_addr_strobe_n = 1'b1;
logic [2:0] option_gp_in_pin_n = 3'h7;
logic [3:0] slow = 4'h0;
wire [31:0] hrdata, dma_addr, dma_wr_data, dma_rd_data, tx_mem_pointer;
wire hreadyout, hresp, rx_room_avail_n, sys_irq_n, dma_burst;
wire dma_wr_req, dma_rd_req, dma_wr_ack, dma_rd_ack, tx_dma_start;
wire [1:0] option_gp_out_pin;
wire [23:0] tx_word_count;
wire [7:0] tx_burst_len, tx_first_burst_len;
int errors = 0;
int cmp_count = 0;
int tx_starts = 0;
logic [31:0] rd;
logic [31:0] wa[$];
logic [31:0] wd[$];
rxd_row_t rows[5] = '{'{`RXD_A_RDP, 32'h12345678, 32'h12345678},
    '{`RXD_A_DPM, 32'hFFFF0000, 32'hFFFF0000},
    '{`RXD_A_RWC, 32'hFFFFFFFF, 32'h00FFFFFF},
    '{`RXD_A_ISR, 32'h0000000F, 32'h00000008},
    '{8'h2C, 32'hDEADBEEF, 32'h00000000}};
rxdma_top #(.AW(3), .PAGE_LOG2(8)) u_rxdma_top (.*, .hsize(3'h2),
    .hready(hreadyout));
rxdma_mem_model u_rxdma_mem_model (.*);
initial
begin
    forever #20 hclk = ~hclk;
end
always @(posedge hclk)
begin
    if (dma_wr_req && dma_wr_ack)
    begin
        wa.push_back(dma_addr);
        wd.push_back(dma_wr_data);
    end
    if (tx_dma_start)
        tx_starts++;
end
////////////////////////////////////////////////////////////////////////////
task automatic chk(input string nm, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp)
    begin
        errors++;
        $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
endtask
task tally_and_finish;
    if (errors == 0 && cmp_count > 0)
        $display("No errors found");
    else
        $display("Errors were found");
    $finish;
endtask
task automatic ahb(input logic w, input logic [31:0] a, d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
endtask
// k holds {tx address, rx address, data}; bus held while strobed
task automatic opt(input logic [2:0] k, input logic [31:0] v);
    @(posedge hclk);
    option_addr_data_bus <= v;
    {tx_addr_strobe_n, rx_addr_strobe_n, rx_data_strobe_n} <= ~k;
    repeat (4) @(posedge hclk);
    {tx_addr_strobe_n, rx_addr_strobe_n, rx_data_strobe_n} <= 3'h7;
    option_addr_data_bus <= ~v;
    repeat (3) @(posedge hclk);
endtask
task automatic wait_wr(input int n);
    for (int i = 0; i < 600 && wa.size() < n; i++) @(posedge hclk);
    chk("writes", wa.size(), n);
endtask
////////////////////////////////////////////////////////////////////////////
initial
begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    chk("room_n", rx_room_avail_n, 1);
    foreach (rows[i])
    begin
        ahb(1, rows[i].a, rows[i].d);
        ahb(0, rows[i].a, 0);
        chk("reg", rd, rows[i].e);
    end
    ahb(1, `RXD_A_MISC, 32'h11);
    ahb(1, `RXD_A_SGP, 32'h800);
    ahb(1, `RXD_A_RWC, 32'h6);
    ahb(1, `RXD_A_IMR, 32'h1);
    ahb(1, `RXD_A_RDP, 32'hF0);
    ahb(1, `RXD_A_OCR, 32'h627);
    repeat (2) @(posedge hclk);
    chk("gpo", option_gp_out_pin, 2'b01);
    opt(3'b010, 32'hF0);
    for (int i = 0; i < 6; i++)
        opt(3'b001, 32'hA0 + i);
    wait_wr(6);
    for (int i = 0; i < 6; i++)
    begin
        chk("waddr", wa[i], (i < 4 ? 32'hF0 : 32'h3FF0) + 4 * i);
        chk("wdata", wd[i], 32'hA0 + i);
    end
    repeat (3) @(posedge hclk);
    chk("irq_n", sys_irq_n, 0);
    ahb(0, `RXD_A_RDP, 0);
    chk("rx_ptr", rd, 32'h4008);
    ahb(0, `RXD_A_SGP, 0);
    chk("table_ptr", rd, 32'h804);
    ahb(1, `RXD_A_ISR, 32'h1);
    repeat (2) @(posedge hclk);
    chk("irq_n", sys_irq_n, 1);
    ahb(1, `RXD_A_OCR, 0);
    ahb(1, `RXD_A_OCR, 32'h21);
    for (int i = 1; i <= 7; i++)
    begin
        opt(3'b001, i);
        chk("room_n", rx_room_avail_n, i == 7);
    end
    slow <= 4'h3;
    ahb(1, `RXD_A_RDP, 32'h2F0);
    ahb(1, `RXD_A_OCR, 32'h23);
    wait_wr(13);
    repeat (4) @(posedge hclk);
    chk("room_n", rx_room_avail_n, 0);
    chk("waddr", wa[12], 32'h308);
    ahb(1, `RXD_A_OCR, 0);
    ahb(1, `RXD_A_RDP, 32'h200);
    ahb(1, `RXD_A_OCR, 32'hC3);
    for (int i = 1; i <= 3; i++)
        opt(3'b001, {4{i[3:0], i[3:0]}});
    wait_wr(14);
    chk("pack", wd[13][31:24], 8'h11);
    ahb(0, `RXD_A_ISR, 0);
    chk("leftover", rd[5:3], 3'b101);
    ahb(0, `RXD_A_PIO, 0);
    chk("partial", rd[15:0], 16'h3322);
    ahb(1, `RXD_A_IMR, 32'h4);
    option_gp_in_pin_n <= 3'b011;
    repeat (6) @(posedge hclk);
    chk("irq_n", sys_irq_n, 0);
    ahb(1, `RXD_A_TDP, 32'h3000);
    ahb(1, `RXD_A_OCR, 32'h103);
    opt(3'b110, 32'h08000020);
    chk("burst", {tx_burst_len, tx_word_count}, 32'h08000020);
    chk("first", tx_first_burst_len, 8'h08);
    opt(3'b100, 32'h3000);
    chk("starts", tx_starts, 1);
    chk("tx_ptr", tx_mem_pointer, 32'h3000);
    tally_and_finish;
end
initial
begin
    #(40 * 20000);
    errors++;
    tally_and_finish;
end
endmodule // tb_top
